// ---- inc/priv_mode_pkg.sv ----
// Constants and types for the privileged library mode controller.
// Assumes a 32-bit classic Wishbone slave port and a single core clock.
package priv_mode_pkg;

    // Opcode classes presented by the issue stage
    typedef enum logic [2:0] {
        OP_NORMAL,
        OP_REG_READ,
        OP_REG_WRITE,
        OP_PHYS_LOAD,
        OP_PHYS_STORE,
        OP_RETURN,
        OP_CALL_LIB
    } issue_op_t;

    // Reason for the latest entry into the mode
    typedef enum logic [2:0] {
        CAUSE_RESET,
        CAUSE_MACHINE_CHECK,
        CAUSE_MATH_FAULT,
        CAUSE_MEMORY_FAULT,
        CAUSE_RESERVED_OPCODE,
        CAUSE_INTERRUPT,
        CAUSE_CALL_LIBRARY
    } cause_t;

    typedef enum logic {
        S_RUN,
        S_DRAIN
    } ctl_state_t;

    // Register byte offsets
    localparam logic [5:0] OFS_STATUS = 6'h00;
    localparam logic [5:0] OFS_MASK = 6'h04;
    localparam logic [5:0] OFS_MODE = 6'h08;
    localparam logic [5:0] OFS_CTRL = 6'h0c;
    localparam logic [5:0] OFS_EXC_LO = 6'h10;
    localparam logic [5:0] OFS_EXC_HI = 6'h14;

    // Status and mask bits
    localparam int ST_WIDTH = 3;
    localparam int ST_ENTRY = 0;
    localparam int ST_RESERVED = 1;
    localparam int ST_RETURN = 2;

    // Mode register fields
    localparam int MODE_FLAG_BIT = 0;
    localparam int MODE_CAUSE_LSB = 4;

    // Control register fields and register reset values
    localparam int CTRL_IRQ_EN_BIT = 0;
    localparam logic [2:0] STATUS_RESET = 3'h0;
    localparam logic [2:0] MASK_RESET = 3'h0;
    localparam logic CTRL_IRQ_EN_RESET = 1'b1;
    localparam logic [63:0] EXCEPTION_RETURN_ADDRESS_RESET = 64'h0000000000000001;

endpackage

// ---- design/mode_op_check.sv ----
// Classifies an issued opcode against the current privileged mode.
// Assumes op and valid come from the issue stage on the same clock.
`timescale 1ns/100ps
module mode_op_check
    import priv_mode_pkg::*;
(
    input wire logic valid_i,
    input wire issue_op_t op_i,
    input wire logic mode_i,
    output logic mode_only_o,
    output logic exec_ok_o,
    output logic reserved_trap_o,
    output logic return_req_o,
    output logic phys_bypass_o
);

    wire logic is_reg_op;
    wire logic is_phys_op;

    assign is_reg_op = (op_i == OP_REG_READ) || (op_i == OP_REG_WRITE);
    assign is_phys_op = (op_i == OP_PHYS_LOAD) || (op_i == OP_PHYS_STORE);
    assign mode_only_o = is_reg_op || is_phys_op || (op_i == OP_RETURN);
    assign exec_ok_o = valid_i && mode_only_o && mode_i;
    assign reserved_trap_o = valid_i && mode_only_o && !mode_i;
    assign return_req_o = exec_ok_o && (op_i == OP_RETURN);
    assign phys_bypass_o = exec_ok_o && is_phys_op;

endmodule

// ---- design/privileged_mode_control.sv ----
// Privileged library mode controller: entry events, drain, dispatch,
// return, machine environment and a Wishbone register file.
// Assumes event and issue inputs come from core logic on clk_i.
//
// Behaviour
// - While in the mode, instruction fetch runs untranslated on physical addresses.
// - While in the mode, data loads and stores stay translated.
// - While in the mode, interrupts are not taken.
// - Reset, machine check, math fault, memory fault, interrupt and library call enter the mode.
// - Five mode-only opcodes exist and the mode has full hardware access.
// - A mode-only opcode outside the mode dispatches to the reserved-opcode entry.
// - Mode-only opcodes access internal registers and return from exceptions.
// - Mode-only physical load and store bypass translation.
// - Program counter bit 0 is the mode flag, set on entry and ignored for fetch alignment.
// - Return jumps to the saved address and takes the mode from its bit 0.
// - Entry drains the pipeline, saves the program counter, then dispatches.
`timescale 1ns/100ps
module privileged_mode_control
    import priv_mode_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic int_o,
    // Core events
    input wire logic machine_check_i,
    input wire logic math_fault_i,
    input wire logic memory_fault_i,
    input wire logic irq_i,
    input wire logic pipe_empty_i,
    input wire logic [63:0] event_pc_i,
    // Issue stage
    input wire logic issue_valid_i,
    input wire issue_op_t issue_op_i,
    // Machine environment
    output logic privileged_library_mode_o,
    output logic instr_translate_en_o,
    output logic data_translate_en_o,
    output logic irq_taken_o,
    output logic drain_req_o,
    output logic dispatch_o,
    output cause_t dispatch_cause_o,
    output logic redirect_o,
    output logic [63:0] redirect_pc_o,
    output logic exec_ok_o,
    output logic phys_bypass_o
);

    ////////////////////////////////////////////////////////////////////////
    // State
    ctl_state_t state;
    logic mode;
    logic [63:0] exception_return_address;
    logic [63:0] saved_pc;
    cause_t cause;
    logic [ST_WIDTH-1:0] status;
    logic [ST_WIDTH-1:0] mask;
    logic irq_en;
    logic reset_entry;

    ////////////////////////////////////////////////////////////////////////
    // Opcode check
    wire logic mode_only;
    wire logic op_exec_ok;
    wire logic op_reserved;
    wire logic op_return;
    wire logic op_phys;

    mode_op_check u_check (
        .valid_i(issue_valid_i && (state == S_RUN)),
        .op_i(issue_op_i),
        .mode_i(mode),
        .mode_only_o(mode_only),
        .exec_ok_o(op_exec_ok),
        .reserved_trap_o(op_reserved),
        .return_req_o(op_return),
        .phys_bypass_o(op_phys)
    );

    ////////////////////////////////////////////////////////////////////////
    // Entry selection, highest priority first
    wire logic call_lib;
    wire logic irq_ok;
    wire logic entry_req;
    wire cause_t entry_cause;
    wire logic drain_done;
    wire logic return_mode;
    wire logic next_mode;

    assign call_lib = issue_valid_i && (state == S_RUN) && (issue_op_i == OP_CALL_LIB);
    assign irq_ok = irq_i && irq_en && !mode;
    assign entry_req = (state == S_RUN) && (reset_entry || machine_check_i || math_fault_i ||
        memory_fault_i || op_reserved || irq_ok || call_lib);
    assign entry_cause = reset_entry ? CAUSE_RESET :
        machine_check_i ? CAUSE_MACHINE_CHECK :
        math_fault_i ? CAUSE_MATH_FAULT :
        memory_fault_i ? CAUSE_MEMORY_FAULT :
        op_reserved ? CAUSE_RESERVED_OPCODE :
        irq_ok ? CAUSE_INTERRUPT : CAUSE_CALL_LIBRARY;
    assign drain_done = (state == S_DRAIN) && pipe_empty_i;
    assign return_mode = exception_return_address[0];
    assign next_mode = drain_done ? 1'b1 :
        (op_return && !entry_req) ? return_mode : mode;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    // drain, save pc, dispatch
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= S_RUN;
            cause <= CAUSE_RESET;
            saved_pc <= EXCEPTION_RETURN_ADDRESS_RESET;
            exception_return_address <= EXCEPTION_RETURN_ADDRESS_RESET;
            reset_entry <= 1'b1;
        end else begin
            unique case (state)
                S_RUN: begin
                    if (entry_req) begin
                        state <= S_DRAIN;
                        cause <= entry_cause;
                        // Reset entry keeps the reset return address
                        saved_pc <= reset_entry ? EXCEPTION_RETURN_ADDRESS_RESET : event_pc_i;
                        reset_entry <= 1'b0;
                    end
                end
                S_DRAIN: begin
                    if (pipe_empty_i) begin
                        state <= S_RUN;
                        exception_return_address <= saved_pc;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode <= 1'b1;
            privileged_library_mode_o <= 1'b1;
            instr_translate_en_o <= 1'b0;
            data_translate_en_o <= 1'b1;
        end else begin
            mode <= next_mode;
            privileged_library_mode_o <= next_mode;
            instr_translate_en_o <= !next_mode;
            data_translate_en_o <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drain_req_o <= 1'b0;
            dispatch_o <= 1'b0;
            dispatch_cause_o <= CAUSE_RESET;
            irq_taken_o <= 1'b0;
            redirect_o <= 1'b0;
            redirect_pc_o <= 64'h0;
            exec_ok_o <= 1'b0;
            phys_bypass_o <= 1'b0;
        end else begin
            drain_req_o <= entry_req || ((state == S_DRAIN) && !pipe_empty_i);
            dispatch_o <= drain_done;
            if (drain_done) begin
                dispatch_cause_o <= cause;
            end
            irq_taken_o <= entry_req && (entry_cause == CAUSE_INTERRUPT);
            redirect_o <= op_return && !entry_req;
            if (op_return && !entry_req) begin
                redirect_pc_o <= {exception_return_address[63:2], 2'b00};
            end
            exec_ok_o <= op_exec_ok && !entry_req;
            phys_bypass_o <= op_phys && !entry_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wishbone register file
    wire logic bus_req;
    wire logic bus_wr;
    wire logic bus_rd;
    wire logic [ST_WIDTH-1:0] events;
    wire logic [31:0] read_mux;
    wire logic status_read;

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];
    assign bus_rd = bus_req && !wb_we_i;
    assign status_read = bus_rd && (wb_adr_i == OFS_STATUS);
    assign events = {op_return && !entry_req, op_reserved, drain_done};
    assign read_mux =
        (wb_adr_i == OFS_STATUS) ? {29'h0, status} :
        (wb_adr_i == OFS_MASK) ? {29'h0, mask} :
        (wb_adr_i == OFS_MODE) ? {25'h0, cause, 3'h0, mode} :
        (wb_adr_i == OFS_CTRL) ? {31'h0, irq_en} :
        (wb_adr_i == OFS_EXC_LO) ? exception_return_address[31:0] :
        (wb_adr_i == OFS_EXC_HI) ? exception_return_address[63:32] : 32'h0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_rd ? read_mux : 32'h0;
        end
    end

    // Set wins over the read clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status <= STATUS_RESET;
            mask <= MASK_RESET;
            irq_en <= CTRL_IRQ_EN_RESET;
            int_o <= 1'b0;
        end else begin
            status <= (status_read ? '0 : status) | events;
            if (bus_wr && (wb_adr_i == OFS_MASK)) begin
                mask <= wb_dat_i[ST_WIDTH-1:0];
            end
            if (bus_wr && (wb_adr_i == OFS_CTRL)) begin
                irq_en <= wb_dat_i[CTRL_IRQ_EN_BIT];
            end
            int_o <= |(((status_read ? '0 : status) | events) & mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    logic past_valid;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            past_valid <= 1'b0;
        end else begin
            past_valid <= 1'b1;
        end
    end

    property p_fetch_physical;
        @(posedge clk_i) disable iff (rst_i)
        privileged_library_mode_o |-> !instr_translate_en_o;
    endproperty
    a_fetch_physical: assert property (p_fetch_physical) else $error("fetch translated in mode");

    property p_data_mapped;
        @(posedge clk_i) disable iff (rst_i)
        past_valid |-> data_translate_en_o;
    endproperty
    a_data_mapped: assert property (p_data_mapped) else $error("data translation off");

    property p_no_irq_in_mode;
        @(posedge clk_i) disable iff (rst_i)
        mode && (state == S_RUN) |=> !irq_taken_o;
    endproperty
    a_no_irq_in_mode: assert property (p_no_irq_in_mode) else $error("irq taken in mode");

    property p_entry_dispatch;
        @(posedge clk_i) disable iff (rst_i)
        entry_req ##1 (pipe_empty_i && state == S_DRAIN) |=> dispatch_o && mode;
    endproperty
    a_entry_dispatch: assert property (p_entry_dispatch) else $error("entry not dispatched");

    property p_reserved_trap;
        @(posedge clk_i) disable iff (rst_i)
        issue_valid_i && (state == S_RUN) && mode_only && !mode && !reset_entry &&
        !machine_check_i && !math_fault_i && !memory_fault_i
        |=> (state == S_DRAIN) && (cause == CAUSE_RESERVED_OPCODE) && !exec_ok_o;
    endproperty
    a_reserved_trap: assert property (p_reserved_trap) else $error("illegal op not trapped");

    property p_phys_only_mode;
        @(posedge clk_i) disable iff (rst_i)
        phys_bypass_o |-> $past(mode) && exec_ok_o;
    endproperty
    a_phys_only_mode: assert property (p_phys_only_mode) else $error("bypass outside mode");

    property p_return_jump;
        @(posedge clk_i) disable iff (rst_i)
        op_return && !entry_req |=> redirect_o &&
        (redirect_pc_o[63:2] == $past(exception_return_address[63:2])) &&
        (mode == $past(exception_return_address[0]));
    endproperty
    a_return_jump: assert property (p_return_jump) else $error("bad return");

    property p_save_pc;
        @(posedge clk_i) disable iff (rst_i)
        (state == S_RUN) && entry_req && !reset_entry ##1 pipe_empty_i
        |=> exception_return_address == $past(event_pc_i, 2);
    endproperty
    a_save_pc: assert property (p_save_pc) else $error("pc not saved");

    property p_flag_set;
        @(posedge clk_i) disable iff (rst_i)
        dispatch_o |-> privileged_library_mode_o;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag clear after entry");

    c_return_native: cover property (@(posedge clk_i) disable iff (rst_i)
        redirect_o && !mode);
    c_irq_entry: cover property (@(posedge clk_i) disable iff (rst_i)
        irq_taken_o ##[1:20] dispatch_o);
    c_reserved: cover property (@(posedge clk_i) disable iff (rst_i)
        dispatch_o && dispatch_cause_o == CAUSE_RESERVED_OPCODE);

endmodule

// ---- verif/privileged_mode_control_tb.sv ----
// Self-checking bench for the privileged library mode controller.
// Assumes the package constants and a Wishbone slave answering one cycle later.
`timescale 1ns/100ps
module privileged_mode_control_tb import priv_mode_pkg::*;;
    localparam logic [63:0] PC = 64'h0000_00ab_0000_1230;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [5:0] wb_adr_i = 6'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic wb_ack_o, int_o, irq_taken_o, drain_req_o, dispatch_o, redirect_o;
    logic machine_check_i = 1'b0, math_fault_i = 1'b0, memory_fault_i = 1'b0, irq_i = 1'b0;
    logic pipe_empty_i = 1'b0, issue_valid_i = 1'b0;
    logic [63:0] event_pc_i = PC, redirect_pc_o;
    issue_op_t issue_op_i = OP_NORMAL;
    logic privileged_library_mode_o, instr_translate_en_o, data_translate_en_o;
    logic exec_ok_o, phys_bypass_o;
    cause_t dispatch_cause_o;
    int n_fail = 0, comparisons = 0;
    cause_t cz[5] = '{CAUSE_MACHINE_CHECK, CAUSE_MATH_FAULT, CAUSE_MEMORY_FAULT,
        CAUSE_INTERRUPT, CAUSE_CALL_LIBRARY};
    issue_op_t ops[5] = '{OP_REG_READ, OP_REG_WRITE, OP_PHYS_LOAD, OP_PHYS_STORE, OP_RETURN};

    privileged_mode_control uut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .int_o(int_o),
        .machine_check_i(machine_check_i), .math_fault_i(math_fault_i),
        .memory_fault_i(memory_fault_i), .irq_i(irq_i), .pipe_empty_i(pipe_empty_i),
        .event_pc_i(event_pc_i), .issue_valid_i(issue_valid_i), .issue_op_i(issue_op_i),
        .privileged_library_mode_o(privileged_library_mode_o),
        .instr_translate_en_o(instr_translate_en_o), .data_translate_en_o(data_translate_en_o),
        .irq_taken_o(irq_taken_o), .drain_req_o(drain_req_o), .dispatch_o(dispatch_o),
        .dispatch_cause_o(dispatch_cause_o), .redirect_o(redirect_o),
        .redirect_pc_o(redirect_pc_o), .exec_ok_o(exec_ok_o), .phys_bypass_o(phys_bypass_o)
    );

    initial begin
        forever #50 clk_i = ~clk_i;
    end

////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // One classic Wishbone cycle; read data lands in rd
    task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hf;
        wb_dat_i <= d;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) break;
        end
        rd = wb_dat_o;
        chk("ack", 1, i < 20);
        if (i == 20) complete_run();
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic rdchk(input string nm, input logic [5:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask

    // Waits for dispatch while holding the pipeline busy for a few cycles
    task automatic settle(input cause_t c, input logic irq_exp);
        int i;
        #1;
        chk("irq_taken", irq_exp, irq_taken_o);
        for (i = 0; i < 20 && dispatch_o !== 1'b1; i++) begin
            @(posedge clk_i);
            if (i == 2) pipe_empty_i <= 1'b1;
            #1;
            if (i == 2) chk("drain", 1, drain_req_o);
        end
        chk("dispatch_late", 1, i > 3 && dispatch_o === 1'b1);
        if (i == 20) complete_run();
        chk("cause", c, dispatch_cause_o);
        chk("mode_in", 1, privileged_library_mode_o);
        chk("itrans_in", 0, instr_translate_en_o);
        chk("dtrans_in", 1, data_translate_en_o);
    endtask

    // no handler reads
    // Issues carry no register selector, so no restricted sequence forms
    task automatic issue(input issue_op_t op);
        @(posedge clk_i);
        issue_valid_i <= 1'b1;
        issue_op_i <= op;
        pipe_empty_i <= 1'b0;
        @(posedge clk_i);
        issue_valid_i <= 1'b0;
        #1;
    endtask

    task automatic enter(input int k);
        @(posedge clk_i);
        pipe_empty_i <= 1'b0;
        machine_check_i <= (k == 0);
        math_fault_i <= (k == 1);
        memory_fault_i <= (k == 2);
        irq_i <= (k == 3);
        issue_valid_i <= (k == 4);
        issue_op_i <= OP_CALL_LIB;
        @(posedge clk_i);
        {machine_check_i, math_fault_i, memory_fault_i, irq_i, issue_valid_i} <= 5'h0;
        settle(cz[k], k == 3);
    endtask

    task automatic ret(input logic [63:0] pc);
        issue(OP_RETURN);
        chk("redirect", 1, redirect_o);
        chk("redirect_pc", {pc[63:2], 2'b00}, redirect_pc_o);
        chk("mode_out", pc[0], privileged_library_mode_o);
        chk("itrans_out", !pc[0], instr_translate_en_o);
        chk("dtrans_out", 1, data_translate_en_o);
    endtask

    // Holds an interrupt request and expects it to be refused
    task automatic irq_hold();
        logic s;
        s = 1'b0;
        @(posedge clk_i);
        irq_i <= 1'b1;
        repeat (4) begin
            @(posedge clk_i);
            #1;
            s = s | irq_taken_o | drain_req_o;
        end
        @(posedge clk_i);
        irq_i <= 1'b0;
        chk("irq_refused", 0, s);
    endtask

////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        chk("mode_rst", 1, privileged_library_mode_o);
        settle(CAUSE_RESET, 1'b0);
        rdchk("exc_lo_rst", OFS_EXC_LO, 32'h1);
        rdchk("ctrl_rst", OFS_CTRL, 32'h1);
        rdchk("mode_reg", OFS_MODE, 32'h1);
        rdchk("unmapped", 6'h20, 32'h0);
        issue(OP_REG_READ);
        chk("exec_ok", 1, exec_ok_o);
        chk("no_bypass", 0, phys_bypass_o);
        issue(OP_PHYS_STORE);
        chk("bypass", 1, phys_bypass_o);
        issue(OP_PHYS_LOAD);
        chk("bypass_ld", 1, phys_bypass_o);
        issue(OP_REG_WRITE);
        chk("exec_wr", 1, exec_ok_o);
        issue(OP_NORMAL);
        chk("exec_plain", 0, exec_ok_o);
        ret(64'h1);
        for (int k = 0; k < 5; k++) begin
            enter(k);
            if (k == 1) begin
                rdchk("exc_lo", OFS_EXC_LO, PC[31:0]);
                rdchk("exc_hi", OFS_EXC_HI, PC[63:32]);
                rdchk("mode_cause", OFS_MODE, 32'h21);
            end
            ret(PC);
        end
        wb(1'b1, OFS_CTRL, 32'h0);
        irq_hold();
        wb(1'b1, OFS_CTRL, 32'h1);
        enter(0);
        irq_hold();
        ret(PC);
        wb(1'b1, OFS_MASK, 32'h2);
        rdchk("mask", OFS_MASK, 32'h2);
        wb(1'b0, OFS_STATUS, 32'h0);
        chk("int_masked", 0, int_o);
        for (int k = 0; k < 5; k++) begin
            issue(ops[k]);
            chk("exec_refused", 0, exec_ok_o);
            settle(CAUSE_RESERVED_OPCODE, 1'b0);
            ret(PC);
        end
        repeat (2) @(posedge clk_i);
        #1;
        chk("int_set", 1, int_o);
        rdchk("status", OFS_STATUS, 32'h7);
        repeat (2) @(posedge clk_i);
        #1;
        chk("int_clear", 0, int_o);
        complete_run();
    end
endmodule
